// [logic/status_error_pkg.sv]
// Shared constants for the status, echo, pacing, error queue and password logic
package status_error_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned QUES_W = 16;   // Questionable register width
  localparam int unsigned CHAR_W = 8;    // Serial character width
  localparam int unsigned CODE_W = 16;   // Error code, two's complement
  localparam int unsigned PASS_W = 16;   // Password value width

  // ------------------------------------------------------------
  // Questionable register bit positions
  // ------------------------------------------------------------
  localparam int unsigned QUES_VE_BIT = 12;  // Voltage error flag
  localparam int unsigned QUES_CE_BIT = 13;  // Current error flag
  localparam int unsigned STB_QUES_BIT = 3;  // Summary position in status byte

  // ------------------------------------------------------------
  // Event status register bit positions
  // ------------------------------------------------------------
  localparam int unsigned ESR_EXEC_BIT = 4;  // Execution error
  localparam int unsigned ESR_CMD_BIT = 5;   // Command error

  // ------------------------------------------------------------
  // Error codes
  // ------------------------------------------------------------
  localparam logic [CODE_W-1:0] ERR_NONE = 16'h0000;       // 0, no error
  localparam logic [CODE_W-1:0] ERR_COMMAND = 16'hff9c;    // -100
  localparam logic [CODE_W-1:0] ERR_NUMERIC = 16'hff88;    // -120
  localparam logic [CODE_W-1:0] ERR_PROTECTED = 16'hff35;  // -203
  localparam logic [CODE_W-1:0] ERR_CONFLICT = 16'hff23;   // -221
  localparam logic [CODE_W-1:0] ERR_RANGE = 16'hff22;      // -222
  localparam logic [CODE_W-1:0] ERR_OVERFLOW = 16'hfea2;   // -350

  // ------------------------------------------------------------
  // Queue sizing and serial constants
  // ------------------------------------------------------------
  localparam int unsigned ERR_DEPTH = 15;          // Entries, overflow marker included
  localparam int unsigned ALL_MAX = 15;            // Most codes in one list reply
  localparam logic [CHAR_W-1:0] LINE_TERM = 8'h0a; // Line terminator character

  // Reset values
  localparam logic [QUES_W-1:0] QUES_ENABLE_RST = 16'h0000;

endpackage : status_error_pkg

// [logic/error_fifo.sv]
// Error queue storage: keeps oldest entries, marks overflow in last slot
`timescale 1ns/1ns
module error_fifo #(
  parameter int unsigned DEPTH = status_error_pkg::ERR_DEPTH,
  parameter int unsigned PW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pushValid,
  input wire logic [status_error_pkg::CODE_W-1:0] pushCode,
  input wire logic popReq,
  input wire logic [PW-1:0] peekIdx,
  output logic [status_error_pkg::CODE_W-1:0] headCode,
  output logic [status_error_pkg::CODE_W-1:0] peekCode,
  output logic [PW-1:0] count
);
  import status_error_pkg::*;

  // ------------------------------------------------------------
  // Storage and pointers
  // ------------------------------------------------------------
  logic [CODE_W-1:0] mem [DEPTH];     // Entry array
  logic [PW-1:0] head_r, head_nxt;    // Oldest entry
  logic [PW-1:0] tail_r, tail_nxt;    // Next free slot
  logic [PW-1:0] count_r, count_nxt;  // Stored entries
  logic doPush;                       // A write lands this cycle
  logic doPop;                        // An entry leaves this cycle
  logic [CODE_W-1:0] wrCode;          // Code actually stored
  logic [PW:0] peekSum;               // Wide head plus offset

  // Wrap an index back into range
  function automatic logic [PW-1:0] wrapInc(input logic [PW-1:0] p);
    if (p == PW'(DEPTH - 1)) begin
      wrapInc = '0;
    end else begin
      wrapInc = p + PW'(1);
    end
  endfunction : wrapInc

  // ------------------------------------------------------------
  // Next-state
  // ------------------------------------------------------------
  // Full queue drops new errors so the oldest stay
  always_comb begin
    doPush = pushValid && (count_r != PW'(DEPTH));
    doPop = popReq && (count_r != '0);
    // The last free slot always takes the overflow marker
    wrCode = (count_r == PW'(DEPTH - 1)) ? ERR_OVERFLOW : pushCode;
    head_nxt = doPop ? wrapInc(head_r) : head_r;
    tail_nxt = doPush ? wrapInc(tail_r) : tail_r;
    count_nxt = count_r;
    if (doPush && !doPop) begin
      count_nxt = count_r + PW'(1);
    end else if (doPop && !doPush) begin
      count_nxt = count_r - PW'(1);
    end
  end

  // Pointer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      head_r <= '0;
      tail_r <= '0;
      count_r <= '0;
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      count_r <= count_nxt;
    end
  end

  // Array write; no reset, contents are only read below count
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[tail_r] <= wrCode;
    end
  end

  // ------------------------------------------------------------
  // Read ports
  // ------------------------------------------------------------
  // First in, first out order from the head
  always_comb begin
    peekSum = {1'b0, head_r} + {1'b0, peekIdx};
    if (peekSum >= (PW + 1)'(DEPTH)) begin
      peekSum = peekSum - (PW + 1)'(DEPTH);
    end
    headCode = mem[head_r];
    peekCode = mem[peekSum[PW-1:0]];
    count = count_r;
  end

endmodule : error_fifo

// [logic/status_error_queue_control.sv]
// Questionable status, serial echo and pacing, error queue and password gate
// Function
// - Enable mask selects events for status bit 3
// - Summary is OR of enabled event bits
// - Enable query returns current mask value
// - Echo on returns every later received character
// - Echo off takes effect after next terminator
// - Reset command leaves echo setting unchanged
// - Echo query reports on or off
// - Pacing XON enables flow control, NONE disables
// - Errors queued first in, first out
// - Empty queue query returns code zero
// - Overflow keeps oldest, last entry is -350
// - Code query returns only next numeric code
// - All-codes query lists up to 15, else 0
// - Matching password sets unlock, permits protected commands
// - Protected command while locked queues -203, ESR4
// - Extra unrecognised content queues -100, ESR5
// - Non-numeric in number queues -120, ESR5
// - Calibration while unlocked but not enabled queues -221, ESR4
// - Value out of range queues -222, ESR4
// - Event register latches, read clears it
// - Only current and voltage error bits latch
`timescale 1ns/1ns
module status_error_queue_control #(
  parameter int unsigned DEPTH = status_error_pkg::ERR_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic quesEnableWrite,
  input wire logic [status_error_pkg::QUES_W-1:0] quesEnableData,
  input wire logic quesEnableRead,
  input wire logic quesEventRead,
  input wire logic currentErrCond,
  input wire logic voltage_error_flag,
  input wire logic echoSetOn,
  input wire logic echoSetOff,
  input wire logic resetCmd,
  input wire logic rxValid,
  input wire logic [status_error_pkg::CHAR_W-1:0] rxChar,
  input wire logic paceSetXon,
  input wire logic paceSetNone,
  input wire logic errRead,
  input wire logic errAllRead,
  input wire logic password_unlock_command,
  input wire logic [status_error_pkg::PASS_W-1:0] unlockValue,
  input wire logic [status_error_pkg::PASS_W-1:0] storedPassword,
  input wire logic diagnostic_save_command,
  input wire logic calCmd,
  input wire logic calEnabled,
  input wire logic extraInfoErr,
  input wire logic numericErr,
  input wire logic rangeErr,
  output logic [status_error_pkg::QUES_W-1:0] quesEnableValue,
  output logic quesEnableValid,
  output logic [status_error_pkg::QUES_W-1:0] quesEventValue,
  output logic quesEventValid,
  output logic quesSummary,
  output logic txValid,
  output logic [status_error_pkg::CHAR_W-1:0] txChar,
  output logic echoActive,
  output logic flowControlOn,
  output logic errValid,
  output logic [status_error_pkg::CODE_W-1:0] errCode,
  output logic allValid,
  output logic [status_error_pkg::CODE_W-1:0] allCode,
  output logic allLast,
  output logic passwordEnabled,
  output logic diagSaveGo,
  output logic calGo,
  output logic esrExecErr,
  output logic esrCmdErr
);
  import status_error_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH + 1);

  // ------------------------------------------------------------
  // Questionable status group
  // ------------------------------------------------------------
  logic [QUES_W-1:0] quesEnable_r, quesEnable_nxt;  // Enable mask
  logic [QUES_W-1:0] quesEvent_r, quesEvent_nxt;    // Latched events
  logic [QUES_W-1:0] quesEnVal_r, quesEnVal_nxt;    // Enable readback
  logic quesEnValid_r, quesEnValid_nxt;             // Enable readback strobe
  logic [QUES_W-1:0] quesEvVal_r, quesEvVal_nxt;    // Event readback
  logic quesEvValid_r, quesEvValid_nxt;             // Event readback strobe
  logic quesSum_r, quesSum_nxt;                     // Summary flag
  logic [QUES_W-1:0] newEvents;                     // Events arriving now

  // Event latching, mask and summary
  always_comb begin
    newEvents = '0;
    newEvents[QUES_CE_BIT] = currentErrCond;
    newEvents[QUES_VE_BIT] = voltage_error_flag;
    // Read clears, but an event in the same cycle survives
    quesEvent_nxt = quesEventRead ? newEvents : (quesEvent_r | newEvents);
    quesEnable_nxt = quesEnableWrite ? quesEnableData : quesEnable_r;
    // Built from next values, so mask or event changes land together
    quesSum_nxt = |(quesEvent_nxt & quesEnable_nxt);
    // Mask read gives the current integer value
    quesEnValid_nxt = quesEnableRead;
    quesEnVal_nxt = quesEnableRead ? quesEnable_r : quesEnVal_r;
    // Event read reports what was latched before the clear
    quesEvValid_nxt = quesEventRead;
    quesEvVal_nxt = quesEventRead ? quesEvent_r : quesEvVal_r;
  end

  // Questionable registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      quesEnable_r <= QUES_ENABLE_RST;
      quesEvent_r <= '0;
      quesSum_r <= 1'b0;
      quesEnVal_r <= '0;
      quesEnValid_r <= 1'b0;
      quesEvVal_r <= '0;
      quesEvValid_r <= 1'b0;
    end else begin
      quesEnable_r <= quesEnable_nxt;
      quesEvent_r <= quesEvent_nxt;
      quesSum_r <= quesSum_nxt;
      quesEnVal_r <= quesEnVal_nxt;
      quesEnValid_r <= quesEnValid_nxt;
      quesEvVal_r <= quesEvVal_nxt;
      quesEvValid_r <= quesEvValid_nxt;
    end
  end

  // ------------------------------------------------------------
  // Serial echo and pacing group
  // ------------------------------------------------------------
  logic echoOn_r, echoOn_nxt;              // Echo in effect
  logic stopPending_r, stopPending_nxt;    // Off requested, awaiting terminator
  logic txValid_r, txValid_nxt;            // Echo strobe
  logic [CHAR_W-1:0] txChar_r, txChar_nxt; // Echoed character
  logic pace_r, pace_nxt;                  // Software flow control on

  // Echo and pacing next-state; resetCmd deliberately absent here
  always_comb begin
    echoOn_nxt = echoOn_r;
    stopPending_nxt = stopPending_r;
    txValid_nxt = 1'b0;
    txChar_nxt = txChar_r;
    if (rxValid && echoOn_r) begin
      // Every received character goes back while echo is on
      txValid_nxt = 1'b1;
      txChar_nxt = rxChar;
      // Terminator is still echoed, echo ends right after it
      if (stopPending_r && (rxChar == LINE_TERM)) begin
        echoOn_nxt = 1'b0;
        stopPending_nxt = 1'b0;
      end
    end
    if (echoSetOn) begin
      // Turning on cancels any pending stop
      echoOn_nxt = 1'b1;
      stopPending_nxt = 1'b0;
    end else if (echoSetOff && echoOn_r) begin
      stopPending_nxt = 1'b1;
    end
    // Pacing select; NONE wins a simultaneous clash as the safer choice
    if (paceSetNone) begin
      pace_nxt = 1'b0;
    end else if (paceSetXon) begin
      pace_nxt = 1'b1;
    end else begin
      pace_nxt = pace_r;
    end
  end

  // Echo and pacing registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      echoOn_r <= 1'b0;
      stopPending_r <= 1'b0;
      txValid_r <= 1'b0;
      txChar_r <= '0;
      pace_r <= 1'b0;
    end else begin
      echoOn_r <= echoOn_nxt;
      stopPending_r <= stopPending_nxt;
      txValid_r <= txValid_nxt;
      txChar_r <= txChar_nxt;
      pace_r <= pace_nxt;
    end
  end

  // ------------------------------------------------------------
  // Password gate and error detection group
  // ------------------------------------------------------------
  logic pwOn_r, pwOn_nxt;            // Password enabled state
  logic diagGo_r, diagGo_nxt;        // Diagnostic save permitted
  logic calGo_r, calGo_nxt;          // Calibration permitted
  logic esrExec_r, esrExec_nxt;      // Execution error strobe
  logic esrCmd_r, esrCmd_nxt;        // Command error strobe
  logic protBlocked;                 // Protected command while locked
  logic calConflict;                 // Unlocked but calibration not enabled
  logic pushValid;                   // An error enters the queue
  logic [CODE_W-1:0] pushCode;       // Code of that error

  // Gate protected commands and pick one error per cycle
  always_comb begin
    // Only an exact match unlocks
    pwOn_nxt = pwOn_r;
    if (password_unlock_command && (unlockValue == storedPassword)) begin
      pwOn_nxt = 1'b1;
    end
    protBlocked = (diagnostic_save_command || calCmd) && !pwOn_r;
    calConflict = calCmd && pwOn_r && !calEnabled;
    diagGo_nxt = diagnostic_save_command && pwOn_r;
    calGo_nxt = calCmd && pwOn_r && calEnabled;
    // Execution class covers -203, -221 and -222
    esrExec_nxt = protBlocked || calConflict || rangeErr;
    // Command class covers -100 and -120
    esrCmd_nxt = extraInfoErr || numericErr;
    // Highest priority error goes in; lower ones the same cycle are dropped
    pushValid = 1'b1;
    if (protBlocked) begin
      pushCode = ERR_PROTECTED;
    end else if (calConflict) begin
      pushCode = ERR_CONFLICT;
    end else if (rangeErr) begin
      pushCode = ERR_RANGE;
    end else if (extraInfoErr) begin
      pushCode = ERR_COMMAND;
    end else if (numericErr) begin
      pushCode = ERR_NUMERIC;
    end else begin
      pushValid = 1'b0;
      pushCode = ERR_NONE;
    end
  end

  // Password and strobe registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwOn_r <= 1'b0;
      diagGo_r <= 1'b0;
      calGo_r <= 1'b0;
      esrExec_r <= 1'b0;
      esrCmd_r <= 1'b0;
    end else begin
      pwOn_r <= pwOn_nxt;
      diagGo_r <= diagGo_nxt;
      calGo_r <= calGo_nxt;
      esrExec_r <= esrExec_nxt;
      esrCmd_r <= esrCmd_nxt;
    end
  end

  // ------------------------------------------------------------
  // Error queue readout group
  // ------------------------------------------------------------
  typedef enum logic [0:0] {LIST_IDLE, LIST_SEND} list_state_e;

  list_state_e listState_r, listState_nxt;  // All-codes streamer
  logic [PW-1:0] listIdx_r, listIdx_nxt;    // Entry being sent
  logic [PW-1:0] listEnd_r, listEnd_nxt;    // Entries to send
  logic errValid_r, errValid_nxt;           // Single code strobe
  logic [CODE_W-1:0] errCode_r, errCode_nxt;
  logic allValid_r, allValid_nxt;           // List element strobe
  logic [CODE_W-1:0] allCode_r, allCode_nxt;
  logic allLast_r, allLast_nxt;             // Final list element
  logic popReq;                             // Remove the head entry
  logic [CODE_W-1:0] headCode;              // Oldest stored code
  logic [CODE_W-1:0] peekCode;              // Code at list index
  logic [PW-1:0] qCount;                    // Stored entries

  error_fifo #(
    .DEPTH(DEPTH),
    .PW(PW)
  ) u_error_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .pushValid(pushValid),
    .pushCode(pushCode),
    .popReq(popReq),
    .peekIdx(listIdx_r),
    .headCode(headCode),
    .peekCode(peekCode),
    .count(qCount)
  );

  // Readout next-state; single reads are refused while a list streams
  always_comb begin
    listState_nxt = listState_r;
    listIdx_nxt = listIdx_r;
    listEnd_nxt = listEnd_r;
    errValid_nxt = 1'b0;
    errCode_nxt = errCode_r;
    allValid_nxt = 1'b0;
    allCode_nxt = allCode_r;
    allLast_nxt = 1'b0;
    popReq = 1'b0;
    case (listState_r)
      LIST_IDLE: begin
        if (errRead) begin
          // Numeric code only; text is formatted elsewhere
          errValid_nxt = 1'b1;
          errCode_nxt = (qCount == '0) ? ERR_NONE : headCode;
          popReq = 1'b1;
        end else if (errAllRead) begin
          if (qCount == '0) begin
            // Empty queue answers a single zero
            allValid_nxt = 1'b1;
            allCode_nxt = ERR_NONE;
            allLast_nxt = 1'b1;
          end else begin
            listState_nxt = LIST_SEND;
            listIdx_nxt = '0;
            // Cap the reply length
            listEnd_nxt = (qCount > PW'(ALL_MAX)) ? PW'(ALL_MAX) : qCount;
          end
        end
      end
      LIST_SEND: begin
        // One code a cycle from the oldest; the queue is not emptied
        allValid_nxt = 1'b1;
        allCode_nxt = peekCode;
        listIdx_nxt = listIdx_r + PW'(1);
        if (listIdx_nxt == listEnd_r) begin
          allLast_nxt = 1'b1;
          listState_nxt = LIST_IDLE;
        end
      end
      default: begin
        listState_nxt = LIST_IDLE;
      end
    endcase
  end

  // Readout registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      listState_r <= LIST_IDLE;
      listIdx_r <= '0;
      listEnd_r <= '0;
      errValid_r <= 1'b0;
      errCode_r <= ERR_NONE;
      allValid_r <= 1'b0;
      allCode_r <= ERR_NONE;
      allLast_r <= 1'b0;
    end else begin
      listState_r <= listState_nxt;
      listIdx_r <= listIdx_nxt;
      listEnd_r <= listEnd_nxt;
      errValid_r <= errValid_nxt;
      errCode_r <= errCode_nxt;
      allValid_r <= allValid_nxt;
      allCode_r <= allCode_nxt;
      allLast_r <= allLast_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ------------------------------------------------------------
  assign quesEnableValue = quesEnVal_r;
  assign quesEnableValid = quesEnValid_r;
  assign quesEventValue = quesEvVal_r;
  assign quesEventValid = quesEvValid_r;
  assign quesSummary = quesSum_r;
  assign txValid = txValid_r;
  assign txChar = txChar_r;
  assign echoActive = echoOn_r;
  assign flowControlOn = pace_r;
  assign errValid = errValid_r;
  assign errCode = errCode_r;
  assign allValid = allValid_r;
  assign allCode = allCode_r;
  assign allLast = allLast_r;
  assign passwordEnabled = pwOn_r;
  assign diagSaveGo = diagGo_r;
  assign calGo = calGo_r;
  assign esrExecErr = esrExec_r;
  assign esrCmdErr = esrCmd_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  summary_tracks_a: assert property (quesSum_r == |(quesEvent_r & quesEnable_r))
    else $error("Summary flag does not match enabled events");
  current_latch_a: assert property (currentErrCond |=> quesEvent_r[QUES_CE_BIT])
    else $error("Current error not latched");
  event_clear_a: assert property (quesEventRead && !currentErrCond && !voltage_error_flag
    |=> quesEvent_r == '0)
    else $error("Event register not cleared by read");
  echo_return_a: assert property (rxValid && echoOn_r
    |=> txValid_r && (txChar_r == $past(rxChar)))
    else $error("Received character not echoed");
  echo_stop_a: assert property (echoOn_r && stopPending_r && rxValid
    && (rxChar == LINE_TERM) && !echoSetOn |=> !echoOn_r ##1 !txValid_r)
    else $error("Echo did not stop after terminator");
  reset_keeps_echo_a: assert property (resetCmd && !rxValid && !echoSetOn && !echoSetOff
    |=> $stable(echoOn_r))
    else $error("Reset command changed echo state");
  pace_select_a: assert property (paceSetXon && !paceSetNone |=> flowControlOn)
    else $error("XON pacing not enabled");
  empty_query_a: assert property (errRead && (qCount == '0) && (listState_r == LIST_IDLE)
    |=> errValid_r && (errCode_r == ERR_NONE))
    else $error("Empty queue did not answer zero");
  unlock_match_a: assert property (password_unlock_command
    && (unlockValue == storedPassword) |=> passwordEnabled)
    else $error("Matching password did not unlock");
  protected_err_a: assert property ((diagnostic_save_command || calCmd) && !pwOn_r
    |=> esrExecErr && !diagSaveGo && !calGo)
    else $error("Locked protected command not refused");
  extra_info_a: assert property (extraInfoErr |=> esrCmdErr)
    else $error("Command error bit not raised");
  overflow_mark_a: assert property ((qCount == PW'(DEPTH - 1)) && pushValid && !popReq
    |=> qCount == PW'(DEPTH))
    else $error("Overflow slot not filled");

endmodule : status_error_queue_control

// [verif/host_serial.sv]
// Host side serial sender for the echo path
`timescale 1ns/1ns
module host_serial (
  input wire logic clk,
  input wire logic sendReq,
  input wire logic [7:0] sendChar,
  output logic rxValid = 1'b0,
  output logic [7:0] rxChar = 8'h00
);
  // One char per request; idle data flips so stale values never look valid
  always @(posedge clk) begin
    rxValid <= sendReq;
    rxChar <= sendReq ? sendChar : ~rxChar;
  end
endmodule : host_serial

// [verif/testbench.sv]
// Bench for the status, echo, pacing, error queue and password block
`timescale 1ns/1ns
module testbench;
  import status_error_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, curE = 1'b0, volE = 1'b0, sreq = 1'b0; // Stimulus
  logic [15:0] cmd = 16'h0000, d = 16'h0000; // Strobes, data word
  logic [7:0] sc = 8'h00, rxC, txC;
  logic [15:0] enV, evV, eC, aC, last;
  logic rxV, enVld, evVld, summ, txV, echo, flow, eV, aV, aL, pw, dGo, cGo, exE, cmE;
  int n_fail = 0, samples_checked = 0, n;
  logic [15:0] q[$] = '{ERR_NUMERIC, ERR_RANGE, ERR_COMMAND, ERR_PROTECTED, ERR_NONE};
  host_serial HOST (.clk(clk), .sendReq(sreq), .sendChar(sc), .rxValid(rxV), .rxChar(rxC));
  status_error_queue_control DUT (.clk(clk), .rst_b(rst_b), .quesEnableWrite(cmd[0]),
    .quesEnableData(d), .quesEnableRead(cmd[1]), .quesEventRead(cmd[2]), .currentErrCond(curE),
    .voltage_error_flag(volE), .echoSetOn(cmd[3]), .echoSetOff(cmd[4]), .resetCmd(cmd[5]),
    .rxValid(rxV), .rxChar(rxC), .paceSetXon(cmd[6]), .paceSetNone(cmd[7]), .errRead(cmd[8]),
    .errAllRead(cmd[9]), .password_unlock_command(cmd[10]), .unlockValue(d),
    .storedPassword(16'h5a5a), .diagnostic_save_command(cmd[11]), .calCmd(cmd[12]),
    .calEnabled(d[0]), .extraInfoErr(cmd[13]), .numericErr(cmd[14]), .rangeErr(cmd[15]),
    .quesEnableValue(enV), .quesEnableValid(enVld), .quesEventValue(evV),
    .quesEventValid(evVld), .quesSummary(summ), .txValid(txV), .txChar(txC),
    .echoActive(echo), .flowControlOn(flow), .errValid(eV), .errCode(eC), .allValid(aV),
    .allCode(aC), .allLast(aL), .passwordEnabled(pw), .diagSaveGo(dGo), .calGo(cGo),
    .esrExecErr(exE), .esrCmdErr(cmE));
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One strobe cycle; returns in the answer cycle
  task automatic go(input int k, input logic [15:0] v);
    @(posedge clk);
    cmd[k] <= 1'b1;
    d <= v;
    @(posedge clk);
    cmd <= 16'h0000;
    #1;
  endtask : go
  // Host sends one char; the partner adds a cycle
  task automatic send(input logic [7:0] c);
    @(posedge clk);
    sreq <= 1'b1;
    sc <= c;
    @(posedge clk);
    sreq <= 1'b0;
    @(posedge clk);
    #1;
  endtask : send
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  initial forever #4 clk = ~clk;
  // Whole run is under two hundred cycles
  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    go(0, 16'h1000);
    go(1, 16'h0000);
    chk("mask", enV, 16'h1000);
    chk("maskvld", 16'(enVld), 16'h0001);
    @(posedge clk) curE <= 1'b1;
    @(posedge clk) curE <= 1'b0;
    @(posedge clk) #1 chk("sum", 16'(summ), 16'h0000);
    @(posedge clk) volE <= 1'b1;
    @(posedge clk) volE <= 1'b0;
    @(posedge clk) #1 chk("sum", 16'(summ), 16'h0001);
    go(2, 16'h0000);
    chk("event", evV, 16'h3000);
    chk("eventvld", 16'(evVld), 16'h0001);
    @(posedge clk) #1 chk("sum", 16'(summ), 16'h0000);
    go(2, 16'h0000);
    chk("event", evV, 16'h0000);
    go(6, 16'h0000);
    chk("pace", 16'(flow), 16'h0001);
    go(7, 16'h0000);
    chk("pace", 16'(flow), 16'h0000);
    go(3, 16'h0000);
    send(8'h41);
    chk("tx", 16'({txV, txC}), 16'h0141);
    go(5, 16'h0000);
    chk("echo", 16'(echo), 16'h0001);
    go(4, 16'h0000);
    send(8'h42);
    chk("tx", 16'({txV, txC}), 16'h0142);
    send(8'h0a);
    chk("tx", 16'({txV, txC, echo}), 16'h0214);
    send(8'h43);
    chk("tx", 16'(txV), 16'h0000);
    go(14, 16'h0000);
    chk("cmd", 16'(cmE), 16'h0001);
    go(15, 16'h0000);
    chk("exec", 16'(exE), 16'h0001);
    go(13, 16'h0000);
    chk("cmd", 16'(cmE), 16'h0001);
    go(11, 16'h0000);
    chk("lock", 16'({dGo, exE}), 16'h0001);
    foreach (q[i]) begin
      go(8, 16'h0000);
      chk("err", eC, q[i]);
      chk("errvld", 16'(eV), 16'h0001);
    end
    go(10, 16'h1111);
    chk("pw", 16'(pw), 16'h0000);
    go(10, 16'h5a5a);
    go(11, 16'h0000);
    chk("save", 16'({pw, dGo}), 16'h0003);
    go(12, 16'h0000);
    chk("cal", 16'({cGo, exE}), 16'h0001);
    go(8, 16'h0000);
    chk("err", eC, ERR_CONFLICT);
    go(12, 16'h0001);
    chk("cal", 16'({cGo, exE}), 16'h0002);
    repeat (16) go(14, 16'h0000);
    go(9, 16'h0000);
    n = 0;
    repeat (20) begin
      @(posedge clk) #1;
      if (aV === 1'b1) n++;
      if (aL === 1'b1) last = aC;
    end
    chk("count", 16'(n), 16'h000f);
    chk("last", last, ERR_OVERFLOW);
    repeat (15) go(8, 16'h0000);
    chk("err", eC, ERR_OVERFLOW);
    go(8, 16'h0000);
    chk("err", eC, ERR_NONE);
    go(9, 16'h0000);
    chk("allempty", 16'({aV, aL}), 16'h0003);
    chk("allcode", aC, ERR_NONE);
    wrap_up();
  end
endmodule : testbench
